// >>> rtl/signal_mixer_pkg.sv
// Purpose: shared constants and types of the signal mixer
// Assumes: 8-bit registers on a small address port
// Notes: offsets are word indices on the register port
package signal_mixer_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] MODULATION_CONTROL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] MODULATION_SOURCE_SELECT_OFS = 4'h1;
   localparam logic [ADDR_W-1:0] HIGH_CARRIER_CONTROL_OFS = 4'h2;
   localparam logic [ADDR_W-1:0] LOW_CARRIER_CONTROL_OFS = 4'h3;
   // modulation_control fields
   localparam int CTL_MODULE_ON = 7;
   localparam int CTL_PIN_DRIVE_ON = 6;
   localparam int CTL_SLEW_LIMIT = 5;
   localparam int CTL_OUTPUT_INVERT = 4;
   localparam int CTL_OUTPUT_STATE = 3;
   localparam int CTL_SW_MOD = 0;
   localparam logic [7:0] CTL_WMASK = 8'hf1;
   // source and carrier register fields
   localparam int SRC_PIN_OFF = 7;
   localparam logic [7:0] SRC_WMASK = 8'h8f;
   localparam int CAR_PIN_OFF = 7;
   localparam int CAR_INVERT = 6;
   localparam int CAR_SYNC = 5;
   localparam logic [7:0] CAR_WMASK = 8'hef;
   // values after reset
   localparam logic [7:0] CTL_RESET = 8'h20;
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] HIGH_CARRIER_RESET = 8'h00;
   localparam logic [7:0] LOW_CARRIER_RESET = 8'h00;
   // modulator source codes
   localparam logic [3:0] MSRC_SW = 4'h0;
   localparam logic [3:0] MSRC_EXT = 4'h1;
   localparam logic [3:0] MSRC_SPI = 4'h2;
   localparam logic [3:0] MSRC_TX0 = 4'h3;
   localparam logic [3:0] MSRC_TX1 = 4'h4;
   localparam logic [3:0] MSRC_PWM0 = 4'h5;
   localparam logic [3:0] MSRC_PWM4 = 4'h9;
   // carrier source codes
   localparam logic [3:0] CSRC_GND = 4'h0;
   localparam logic [3:0] CSRC_EXT_A = 4'h1;
   localparam logic [3:0] CSRC_EXT_B = 4'h2;
   localparam logic [3:0] CSRC_REF = 4'h3;
   localparam logic [3:0] CSRC_PWM0 = 4'h4;
   localparam logic [3:0] CSRC_PWM4 = 4'h8;

   typedef struct packed {
      logic [4:0] pwm;
      logic [1:0] tx;
      logic spi;
      logic ref_clk;
      logic ext_modulator_pin;
      logic ext_carrier_pin_a;
      logic ext_carrier_pin_b;
   } sources_t;

   typedef struct packed {
      logic [4:0] pwm;
      logic [1:0] tx;
      logic spi;
      logic ref_clk;
   } pin_off_t;

   typedef enum logic [1:0] {
      CARRIER_LOW = 2'b01,
      CARRIER_HIGH = 2'b10
   } carrier_state_t;
endpackage

// >>> rtl/signal_mixer.sv
// Purpose: mixes a modulator stream with high and low carriers
// Assumes: all source inputs synchronous to core_clk
// Notes: pin outputs and pin_off flags are registered
`timescale 1ns/1ns
module signal_mixer
   import signal_mixer_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire sources_t src_in,
   output logic modulated_out_pin,
   output logic slew_limit_sel,
   output pin_off_t pin_off
);
   logic rst_sync1_reg;
   logic rst_n_reg;
   logic [7:0] ctl_reg;
   logic [7:0] src_reg;
   logic [7:0] high_carrier_reg;
   logic [7:0] low_carrier_reg;
   carrier_state_t state_reg;
   carrier_state_t state_next;
   logic out_state_reg;
   logic mdo_sync1_reg;
   logic mdo_sync2_reg;
   logic module_on;
   logic mod_eff;
   logic high_carrier_eff;
   logic low_carrier_eff;
   logic high_carrier_raw;
   logic low_carrier_raw;
   logic mixed;
   logic [7:0] rdata_next;
   pin_off_t pin_off_next;

   // reset released through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n_reg <= rst_sync1_reg;
      end
   end

   // register writes; reserved bits stay zero
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctl_reg <= CTL_RESET;
         src_reg <= SRC_RESET;
         high_carrier_reg <= HIGH_CARRIER_RESET;
         low_carrier_reg <= LOW_CARRIER_RESET;
      end else if (reg_write) begin
         unique case (reg_addr)
            MODULATION_CONTROL_OFS: ctl_reg <= reg_wdata & CTL_WMASK;
            MODULATION_SOURCE_SELECT_OFS: src_reg <= reg_wdata & SRC_WMASK;
            HIGH_CARRIER_CONTROL_OFS: high_carrier_reg <= reg_wdata & CAR_WMASK;
            LOW_CARRIER_CONTROL_OFS: low_carrier_reg <= reg_wdata & CAR_WMASK;
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      unique case (reg_addr)
         MODULATION_CONTROL_OFS: begin
            rdata_next = ctl_reg;
            rdata_next[CTL_OUTPUT_STATE] = mdo_sync2_reg;
         end
         MODULATION_SOURCE_SELECT_OFS: rdata_next = src_reg;
         HIGH_CARRIER_CONTROL_OFS: rdata_next = high_carrier_reg;
         LOW_CARRIER_CONTROL_OFS: rdata_next = low_carrier_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign module_on = ctl_reg[CTL_MODULE_ON];

   // modulator source; disabled falls back to software bit
   always_comb begin
      mod_eff = 1'b0;
      if (!module_on) begin
         mod_eff = ctl_reg[CTL_SW_MOD];
      end else begin
         unique case (src_reg[3:0])
            MSRC_SW: mod_eff = ctl_reg[CTL_SW_MOD];
            MSRC_EXT: mod_eff = src_in.ext_modulator_pin;
            MSRC_SPI: mod_eff = src_in.spi;
            MSRC_TX0: mod_eff = src_in.tx[0];
            MSRC_TX1: mod_eff = src_in.tx[1];
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9:
               mod_eff = src_in.pwm[3'(src_reg[3:0] - MSRC_PWM0)];
            default: mod_eff = 1'b0;
         endcase
      end
   end

   function automatic logic pick_carrier(input logic [3:0] code,
                                         input sources_t s);
      logic v;
      v = 1'b0;
      unique case (code)
         CSRC_GND: v = 1'b0;
         CSRC_EXT_A: v = s.ext_carrier_pin_a;
         CSRC_EXT_B: v = s.ext_carrier_pin_b;
         CSRC_REF: v = s.ref_clk;
         4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
            v = s.pwm[3'(code - CSRC_PWM0)];
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   assign high_carrier_raw = pick_carrier(high_carrier_reg[3:0], src_in);
   assign low_carrier_raw = pick_carrier(low_carrier_reg[3:0], src_in);

   // polarity applies to the selected source; ground when disabled
   always_comb begin
      high_carrier_eff = 1'b0;
      low_carrier_eff = 1'b0;
      if (module_on) begin
         high_carrier_eff = high_carrier_raw ^ high_carrier_reg[CAR_INVERT];
         low_carrier_eff = low_carrier_raw ^ low_carrier_reg[CAR_INVERT];
      end
   end

   // carrier switch; a synced carrier finishes its pulse first
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CARRIER_HIGH: begin
            if (!mod_eff && !(high_carrier_reg[CAR_SYNC] && high_carrier_eff)) begin
               state_next = CARRIER_LOW;
            end
         end
         CARRIER_LOW: begin
            if (mod_eff && !(low_carrier_reg[CAR_SYNC] && low_carrier_eff)) begin
               state_next = CARRIER_HIGH;
            end
         end
         default: state_next = CARRIER_LOW;
      endcase
   end

   // with no sync this equals mod ? high_carrier : low_carrier
   assign mixed = (state_next == CARRIER_HIGH) ? high_carrier_eff
      : low_carrier_eff;

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= CARRIER_LOW;
      end else begin
         state_reg <= state_next;
      end
   end

   // nothing here depends on a sleep state
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         modulated_out_pin <= 1'b0;
         out_state_reg <= 1'b0;
      end else begin
         out_state_reg <= mixed;
         modulated_out_pin <= module_on && ctl_reg[CTL_PIN_DRIVE_ON]
            && (mixed ^ ctl_reg[CTL_OUTPUT_INVERT]);
      end
   end

   // fast carriers may alias here; the bit is best effort
   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mdo_sync1_reg <= 1'b0;
         mdo_sync2_reg <= 1'b0;
      end else begin
         mdo_sync1_reg <= out_state_reg;
         mdo_sync2_reg <= mdo_sync1_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         slew_limit_sel <= CTL_RESET[CTL_SLEW_LIMIT];
      end else begin
         slew_limit_sel <= ctl_reg[CTL_SLEW_LIMIT];
      end
   end

   // a carrier claims only peripherals that own a pin
   function automatic pin_off_t carrier_claim(input logic [7:0] c);
      pin_off_t p;
      p = '0;
      if (c[CAR_PIN_OFF]) begin
         if (c[3:0] == CSRC_REF) begin
            p.ref_clk = 1'b1;
         end else if (c[3:0] >= CSRC_PWM0 && c[3:0] <= CSRC_PWM4) begin
            p.pwm[3'(c[3:0] - CSRC_PWM0)] = 1'b1;
         end
      end
      return p;
   endfunction

   // peripherals keep their pins unless the mixer claims them
   always_comb begin
      pin_off_next = '0;
      if (module_on) begin
         if (src_reg[SRC_PIN_OFF]) begin
            unique case (src_reg[3:0])
               MSRC_SPI: pin_off_next.spi = 1'b1;
               MSRC_TX0: pin_off_next.tx[0] = 1'b1;
               MSRC_TX1: pin_off_next.tx[1] = 1'b1;
               4'h5, 4'h6, 4'h7, 4'h8, 4'h9:
                  pin_off_next.pwm[3'(src_reg[3:0] - MSRC_PWM0)] = 1'b1;
               default: ;
            endcase
         end
         pin_off_next = pin_off_t'(pin_off_next | carrier_claim(high_carrier_reg)
            | carrier_claim(low_carrier_reg));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_off <= '0;
      end else begin
         pin_off <= pin_off_next;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n_reg);

   AST_PIN_LOW_NO_DRIVE: assert property (
      !ctl_reg[CTL_PIN_DRIVE_ON] |=> !modulated_out_pin)
      else $error("pin high while drive off");
   AST_OFF_NO_OUTPUT: assert property (
      !module_on |=> !modulated_out_pin)
      else $error("pin high while module off");
   AST_POLARITY: assert property (
      module_on && ctl_reg[CTL_PIN_DRIVE_ON] |=>
      modulated_out_pin == ($past(mixed) ^ $past(ctl_reg[CTL_OUTPUT_INVERT])))
      else $error("pin value not inverted mix");
   AST_SLEW: assert property (
      ##1 slew_limit_sel == $past(ctl_reg[CTL_SLEW_LIMIT]))
      else $error("slew output mismatch");
   AST_DISABLED_GND: assert property (
      !module_on |-> !high_carrier_eff && !low_carrier_eff
      && mod_eff == ctl_reg[CTL_SW_MOD])
      else $error("disabled sources not forced");
   AST_SW_MOD: assert property (
      src_reg[3:0] == MSRC_SW |-> mod_eff == ctl_reg[CTL_SW_MOD])
      else $error("software bit not the modulator");
   AST_HIGH_SYNC: assert property (
      state_reg == CARRIER_HIGH && high_carrier_reg[CAR_SYNC] && high_carrier_eff
      |=> state_reg == CARRIER_HIGH)
      else $error("left high carrier before falling edge");
   AST_LOW_SYNC: assert property (
      state_reg == CARRIER_LOW && low_carrier_reg[CAR_SYNC] && low_carrier_eff
      |=> state_reg == CARRIER_LOW)
      else $error("left low carrier before falling edge");
   AST_NO_SYNC_SWITCH: assert property (
      !high_carrier_reg[CAR_SYNC] && !low_carrier_reg[CAR_SYNC] |->
      mixed == (mod_eff ? high_carrier_eff : low_carrier_eff))
      else $error("unsynced mix wrong");
   AST_MDO_SYNC: assert property (
      ##2 mdo_sync2_reg == $past(out_state_reg, 2))
      else $error("output state sync latency wrong");
   AST_HI_INVERT: assert property (
      module_on && high_carrier_reg[3:0] == CSRC_REF |->
      high_carrier_eff == (src_in.ref_clk ^ high_carrier_reg[CAR_INVERT]))
      else $error("high carrier polarity wrong");
   AST_RESET_DEFAULT: assert property (
      $rose(rst_n_reg) |-> ctl_reg == CTL_RESET && src_reg == SRC_RESET)
      else $error("registers not at defaults");

   // source decoding, switching, state read-back, output gating and pin claims
   AST_LO_INVERT: assert property (
      module_on && low_carrier_reg[3:0] == CSRC_REF |->
      low_carrier_eff == (src_in.ref_clk ^ low_carrier_reg[CAR_INVERT]))
      else $error("low carrier polarity wrong");
   AST_EXT_MOD: assert property (
      module_on && src_reg[3:0] == MSRC_EXT |->
      mod_eff == src_in.ext_modulator_pin)
      else $error("modulator pin not selected");
   AST_RESERVED_MOD: assert property (
      module_on && src_reg[3:0] > MSRC_PWM4 |-> !mod_eff)
      else $error("reserved modulator code not quiet");
   AST_RESERVED_HI: assert property (
      module_on && high_carrier_reg[3:0] > CSRC_PWM4 |->
      high_carrier_eff == high_carrier_reg[CAR_INVERT])
      else $error("reserved high carrier code not ground");
   AST_RESERVED_LO: assert property (
      module_on && low_carrier_reg[3:0] > CSRC_PWM4 |->
      low_carrier_eff == low_carrier_reg[CAR_INVERT])
      else $error("reserved low carrier code not ground");
   AST_HIGH_LEAVE: assert property (
      state_reg == CARRIER_HIGH && !mod_eff && !high_carrier_eff
      |=> state_reg == CARRIER_LOW)
      else $error("high carrier held after it fell");
   AST_LOW_LEAVE: assert property (
      state_reg == CARRIER_LOW && mod_eff && !low_carrier_eff
      |=> state_reg == CARRIER_HIGH)
      else $error("low carrier held after it fell");
   AST_STATE_BIT: assert property (
      reg_read && reg_addr == MODULATION_CONTROL_OFS |=>
      reg_rdata[CTL_OUTPUT_STATE] == $past(mdo_sync2_reg))
      else $error("state bit not the synced output");
   AST_GATE_AFTER_INVERT: assert property (
      ctl_reg[CTL_OUTPUT_INVERT] && !ctl_reg[CTL_PIN_DRIVE_ON]
      |=> !modulated_out_pin)
      else $error("inverted output leaked past gate");
   AST_OFF_PINS_KEPT: assert property (
      !module_on |=> pin_off == '0)
      else $error("pin claimed while module off");
   AST_MOD_PIN_OFF: assert property (
      module_on && src_reg[SRC_PIN_OFF] && src_reg[3:0] == MSRC_SPI
      |=> pin_off.spi)
      else $error("modulator peripheral kept its pin");
   AST_PWM_PIN_OFF: assert property (
      module_on && src_reg[SRC_PIN_OFF] && src_reg[3:0] == 4'h7
      |=> pin_off.pwm[2])
      else $error("modulator pwm kept its pin");
   AST_MOD_PIN_KEPT: assert property (
      !src_reg[SRC_PIN_OFF] |=> !pin_off.spi && pin_off.tx == 2'b00)
      else $error("modulator peripheral lost its pin");
   AST_CAR_PIN_OFF: assert property (
      module_on && high_carrier_reg[CAR_PIN_OFF] && high_carrier_reg[3:0] == 4'h5
      |=> pin_off.pwm[1])
      else $error("carrier peripheral kept its pin");
   AST_CAR_PIN_KEPT: assert property (
      !high_carrier_reg[CAR_PIN_OFF] && !low_carrier_reg[CAR_PIN_OFF]
      |=> !pin_off.ref_clk)
      else $error("carrier peripheral lost its pin");
   AST_LOW_CAR_PIN_OFF: assert property (
      module_on && low_carrier_reg[CAR_PIN_OFF] && low_carrier_reg[3:0] == CSRC_PWM0
      |=> pin_off.pwm[0])
      else $error("low carrier peripheral kept its pin");
endmodule

// >>> verif/source_model.sv
// Purpose: on-chip source peripherals and pins feeding the mixer
// Assumes: sources change just after core_clk rises
// Notes: stall freezes every source, as a slow peripheral would
`timescale 1ns/1ns
module source_model
   import signal_mixer_pkg::*;
(
   input wire logic core_clk,
   input wire logic stall,
   output sources_t src
);
   logic [7:0] cnt_reg = 8'h00;
   always_ff @(posedge core_clk) begin
      if (!stall) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
   // slow pwm carriers against faster modulators so syncs must wait
   always_comb begin
      src.pwm = cnt_reg[6:2];
      src.tx = cnt_reg[4:3];
      src.spi = cnt_reg[5];
      src.ref_clk = cnt_reg[0];
      src.ext_modulator_pin = cnt_reg[6] ^ cnt_reg[3];
      src.ext_carrier_pin_a = cnt_reg[1];
      src.ext_carrier_pin_b = ^cnt_reg[1:0];
   end
endmodule

// >>> verif/signal_mixer_test.sv
// Purpose: self-checking bench for the signal mixer
// Assumes: register port answers reads one cycle later
// Notes: a cycle model tracks pin, slew and pin_off every cycle
`timescale 1ns/1ns
module signal_mixer_test;
   import signal_mixer_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic stall = 1'b0;
   logic modulated_out_pin;
   logic slew_limit_sel;
   pin_off_t pin_off;
   sources_t src;
   int errors = 0;
   int comparisons = 0;
   logic [7:0] ctl_m, src_m, high_carrier_m, low_carrier_m;
   logic st, ep, es, md, hi, lo, cur;
   logic [8:0] epo;
   logic [15:0] mv, cv, m, h, l;
   logic [3:0] k;

   always #10 core_clk = ~core_clk;

   source_model source_model_inst (.core_clk(core_clk), .stall(stall),
      .src(src));
   signal_mixer signal_mixer_inst (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .src_in(src),
      .modulated_out_pin(modulated_out_pin),
      .slew_limit_sel(slew_limit_sel), .pin_off(pin_off));

   // cycle model: sources at one edge show on the pins after that edge, register writes after the next
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_m <= CTL_RESET;
         src_m <= SRC_RESET;
         high_carrier_m <= HIGH_CARRIER_RESET;
         low_carrier_m <= LOW_CARRIER_RESET;
         st <= 1'b0;
         ep <= 1'b0;
         es <= 1'b1;
         epo <= 9'h000;
      end else begin
         mv = {6'h00, src.pwm, src.tx, src.spi, src.ext_modulator_pin,
            ctl_m[0]};
         cv = {7'h00, src.pwm, src.ref_clk, src.ext_carrier_pin_b,
            src.ext_carrier_pin_a, 1'b0};
         md = ctl_m[7] ? mv[src_m[3:0]] : ctl_m[0];
         hi = ctl_m[7] & (cv[high_carrier_m[3:0]] ^ high_carrier_m[6]);
         lo = ctl_m[7] & (cv[low_carrier_m[3:0]] ^ low_carrier_m[6]);
         cur = (st ? (!high_carrier_m[5] | !hi) : (!low_carrier_m[5] | !lo)) ? md : st;
         st <= cur;
         ep <= ctl_m[7] & ctl_m[6] & ((cur ? hi : lo) ^ ctl_m[4]);
         es <= ctl_m[5];
         m = src_m[7] ? 16'h0001 << src_m[3:0] : 16'h0000;
         h = high_carrier_m[7] ? 16'h0001 << high_carrier_m[3:0] : 16'h0000;
         l = low_carrier_m[7] ? 16'h0001 << low_carrier_m[3:0] : 16'h0000;
         epo <= ctl_m[7] ? {m[9:5] | h[8:4] | l[8:4], m[4:3], m[2],
            h[3] | l[3]} : 9'h000;
         if (reg_write) begin
            case (reg_addr)
               4'h0: ctl_m <= reg_wdata & CTL_WMASK;
               4'h1: src_m <= reg_wdata & SRC_WMASK;
               4'h2: high_carrier_m <= reg_wdata & CAR_WMASK;
               4'h3: low_carrier_m <= reg_wdata & CAR_WMASK;
               default: ;
            endcase
         end
      end
   end

   task check(input string n, input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   always @(negedge core_clk) begin
      if (reset_n) begin
         check("pin", {8'h00, ep}, {8'h00, modulated_out_pin});
         check("slew", {8'h00, es}, {8'h00, slew_limit_sel});
         check("pin_off", epo, pin_off);
      end
   end

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] mk);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(negedge core_clk);
      check("rdata", {1'b0, e & mk}, {1'b0, reg_rdata & mk});
   endtask

   task results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      results();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(4'h0, CTL_RESET, 8'hff);
      rd(4'h1, SRC_RESET, 8'hff);
      rd(4'h2, HIGH_CARRIER_RESET, 8'hff);
      rd(4'h3, LOW_CARRIER_RESET, 8'hff);
      for (int i = 0; i < 16; i++) begin
         k = i[3:0];
         wr({1'b1, k[2:0]}, 8'hff);
         wr(4'h1, {k[1], 3'h7, k});
         wr(4'h2, {k[0], k[2], k[1], 1'b1, k});
         wr(4'h3, {k[1], k[0], k[2], 1'b1, ~k});
         wr(4'h0, {k != 4'h3, k != 4'h6, k[0], k[2], 3'h7, k[1]});
         stall <= k[3] & k[0];
         repeat (40) @(posedge core_clk);
         rd(4'h1, {k[1], 3'h0, k}, 8'hff);
         rd(4'h2, {k[0], k[2], k[1], 1'b0, k}, 8'hff);
         rd(4'h3, {k[1], k[0], k[2], 1'b0, ~k}, 8'hff);
         rd(4'h0, {k != 4'h3, k != 4'h6, k[0], k[2], 3'h0, k[1]},
            8'hf7);
         rd({1'b1, k[2:0]}, 8'h00, 8'hff);
      end
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h40);
      wr(4'h0, 8'hc1);
      repeat (6) @(posedge core_clk);
      rd(4'h0, 8'hc9, 8'hff);
      wr(4'h0, 8'h81);
      repeat (6) @(posedge core_clk);
      rd(4'h0, 8'h89, 8'hff);
      wr(4'h3, 8'h00);
      wr(4'h2, 8'h00);
      repeat (6) @(posedge core_clk);
      rd(4'h0, 8'h81, 8'hff);
      results();
   end
endmodule
